// ===== design/lic_pkg.sv
// Constants and types for the LED intensity and colour-mix register bank
// Summary of operation
// - Five intensity bytes, 0Ah-0Eh, reset FFh
// - Intensity FFh drives module at full level
// - Intensity 80h drives module at half level
// - Intensity 00h turns module output off
// - Four colour-mix bytes, 0Fh-12h, reset 00h
// - Mix FFh gives full colour share
// - Mix 80h gives half colour share
// - Mix 00h gives no colour share
package lic_pkg;

    localparam int LIC_NUM_MOD = 5;
    localparam int LIC_NUM_CH  = 4;

    // Word indexes; byte address is four times the index
    localparam logic [9:0] LIC_IDX_MODULE3 = 10'h00a;
    localparam logic [9:0] LIC_IDX_MODULE4 = 10'h00b;
    localparam logic [9:0] LIC_IDX_MODULE5 = 10'h00c;
    localparam logic [9:0] LIC_IDX_MODULE6 = 10'h00d;
    localparam logic [9:0] LIC_IDX_MODULE7 = 10'h00e;
    localparam logic [9:0] LIC_IDX_CH0     = 10'h00f;
    localparam logic [9:0] LIC_IDX_CH1     = 10'h010;
    localparam logic [9:0] LIC_IDX_CH2     = 10'h011;
    localparam logic [9:0] LIC_IDX_CH3     = 10'h012;
    localparam logic [9:0] LIC_IDX_CTRL    = 10'h040;
    localparam logic [9:0] LIC_IDX_STATUS  = 10'h041;

    localparam logic [9:0] LIC_IDX_MOD [LIC_NUM_MOD] = '{
        LIC_IDX_MODULE3, LIC_IDX_MODULE4, LIC_IDX_MODULE5,
        LIC_IDX_MODULE6, LIC_IDX_MODULE7};
    localparam logic [9:0] LIC_IDX_CHN [LIC_NUM_CH] = '{
        LIC_IDX_CH0, LIC_IDX_CH1, LIC_IDX_CH2, LIC_IDX_CH3};

    // Values after reset
    localparam logic [7:0] LIC_INT_RST  = 8'hff;
    localparam logic [7:0] LIC_MIX_RST  = 8'h00;
    localparam logic [1:0] LIC_CTRL_RST = 2'h1;

    // Control bit positions
    localparam int LIC_CTRL_EN_BIT     = 0;
    localparam int LIC_CTRL_FREEZE_BIT = 1;

    // Status field positions
    localparam int LIC_STAT_PEND_BIT = 8;

    // Phase runs 0..FEh so code FFh is always on and 00h never
    localparam logic [7:0] LIC_PHASE_LAST = 8'hfe;

    // Clock cycles per phase step
    localparam logic [3:0] LIC_STEP_CYCLES = 4'h4;

    // AHB encodings
    localparam logic [1:0] LIC_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] LIC_HSIZE_BYTE    = 3'h0;
    localparam logic [2:0] LIC_HSIZE_HALF    = 3'h1;

    typedef struct packed {
        logic [LIC_NUM_MOD-1:0][7:0] module_level;
        logic [LIC_NUM_CH-1:0][7:0]  channel_level;
    } lic_levels_t;

endpackage

// ===== design/lic_scale.sv
// Proportional duty generator for one level byte
`timescale 1ns/100ps
`default_nettype none
module lic_scale (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Shared timing
    input  wire logic       enable,
    input  wire logic [7:0] phase,
    // Level
    input  wire logic [7:0] code,
    // Drive
    output logic            drive
);
    import lic_pkg::*;

    // On for code steps out of FFh phase steps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive <= 1'b0;
        end else begin
            drive <= enable & (phase < code);
        end
    end

endmodule
`default_nettype wire

// ===== design/lic_regs.sv
// AHB-Lite register bank for module intensity and channel colour mix
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module lic_regs (
    // Clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // AHB-Lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic [31:0]             hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    // Levels to the PWM stage
    output lic_pkg::lic_levels_t    levels,
    // Proportional drives
    output logic [4:0]              module_drive,
    output logic [3:0]              channel_drive
);
    import lic_pkg::*;

    // Register storage
    logic [7:0]  module_reg  [LIC_NUM_MOD];
    logic [7:0]  module_next [LIC_NUM_MOD];
    logic [7:0]  channel_reg  [LIC_NUM_CH];
    logic [7:0]  channel_next [LIC_NUM_CH];
    logic [1:0]  ctrl_reg;
    logic [1:0]  ctrl_next;

    // Data phase state
    logic        dp_write_reg;
    logic [9:0]  dp_idx_reg;
    logic        dp_lane_reg;

    // Phase timing
    logic [3:0]  div_reg;
    logic        step_reg;
    logic [7:0]  phase_reg;
    logic        wrap;

    // Address phase decode
    logic        addr_ok;
    logic [9:0]  addr_idx;
    logic        addr_lane;
    logic        pending;
    logic [31:0] rd_value;

    assign addr_ok  = hsel & hready & htrans[1];
    assign addr_idx = haddr[11:2];
    assign wrap     = step_reg & (phase_reg == LIC_PHASE_LAST);

    // Low byte lane is touched by this size and address
    always_comb begin
        addr_lane = 1'b1;
        if (hsize == LIC_HSIZE_BYTE) begin
            addr_lane = (haddr[1:0] == 2'h0);
        end else if (hsize == LIC_HSIZE_HALF) begin
            addr_lane = ~haddr[1];
        end
    end

    // Address phase captured for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write_reg <= 1'b0;
            dp_idx_reg   <= 10'h000;
            dp_lane_reg  <= 1'b0;
        end else if (hready) begin
            dp_write_reg <= addr_ok & hwrite;
            dp_idx_reg   <= addr_idx;
            dp_lane_reg  <= addr_lane;
        end
    end

    // Intensity register write path
    always_comb begin
        for (int m = 0; m < LIC_NUM_MOD; m++) begin
            module_next[m] = module_reg[m];
            if (dp_write_reg && dp_lane_reg && dp_idx_reg == LIC_IDX_MOD[m]) begin
                module_next[m] = hwdata[7:0];
            end
        end
    end

    // Colour-mix register write path
    always_comb begin
        for (int c = 0; c < LIC_NUM_CH; c++) begin
            channel_next[c] = channel_reg[c];
            if (dp_write_reg && dp_lane_reg && dp_idx_reg == LIC_IDX_CHN[c]) begin
                channel_next[c] = hwdata[7:0];
            end
        end
    end

    // Control register write path
    always_comb begin
        ctrl_next = ctrl_reg;
        if (dp_write_reg && dp_lane_reg && dp_idx_reg == LIC_IDX_CTRL) begin
            ctrl_next = hwdata[1:0];
        end
    end

    // Intensity registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int m = 0; m < LIC_NUM_MOD; m++) begin
                module_reg[m] <= LIC_INT_RST;
            end
        end else begin
            for (int m = 0; m < LIC_NUM_MOD; m++) begin
                module_reg[m] <= module_next[m];
            end
        end
    end

    // Colour-mix registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int c = 0; c < LIC_NUM_CH; c++) begin
                channel_reg[c] <= LIC_MIX_RST;
            end
        end else begin
            for (int c = 0; c < LIC_NUM_CH; c++) begin
                channel_reg[c] <= channel_next[c];
            end
        end
    end

    // Control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= LIC_CTRL_RST;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Live levels differ from programmed ones
    always_comb begin
        pending = 1'b0;
        for (int m = 0; m < LIC_NUM_MOD; m++) begin
            if (levels.module_level[m] != module_reg[m]) begin
                pending = 1'b1;
            end
        end
        for (int c = 0; c < LIC_NUM_CH; c++) begin
            if (levels.channel_level[c] != channel_reg[c]) begin
                pending = 1'b1;
            end
        end
    end

    // Read value, forwarded from the write in flight
    always_comb begin
        rd_value = 32'h0000_0000;
        for (int m = 0; m < LIC_NUM_MOD; m++) begin
            if (addr_idx == LIC_IDX_MOD[m]) begin
                rd_value[7:0] = module_next[m];
            end
        end
        for (int c = 0; c < LIC_NUM_CH; c++) begin
            if (addr_idx == LIC_IDX_CHN[c]) begin
                rd_value[7:0] = channel_next[c];
            end
        end
        if (addr_idx == LIC_IDX_CTRL) begin
            rd_value[1:0] = ctrl_next;
        end
        if (addr_idx == LIC_IDX_STATUS) begin
            rd_value[7:0]             = phase_reg;
            rd_value[LIC_STAT_PEND_BIT] = pending;
        end
    end

    // Read data stands through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready) begin
            if (addr_ok && !hwrite) begin
                hrdata <= rd_value;
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Phase step enable divider
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg  <= 4'h0;
            step_reg <= 1'b0;
        end else if (div_reg == LIC_STEP_CYCLES - 4'h1) begin
            div_reg  <= 4'h0;
            step_reg <= 1'b1;
        end else begin
            div_reg  <= div_reg + 4'h1;
            step_reg <= 1'b0;
        end
    end

    // Phase counter over FFh steps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_reg <= 8'h00;
        end else if (wrap) begin
            phase_reg <= 8'h00;
        end else if (step_reg) begin
            phase_reg <= phase_reg + 8'h01;
        end
    end

    // Levels change only at period end to avoid runt pulses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int m = 0; m < LIC_NUM_MOD; m++) begin
                levels.module_level[m] <= LIC_INT_RST;
            end
            for (int c = 0; c < LIC_NUM_CH; c++) begin
                levels.channel_level[c] <= LIC_MIX_RST;
            end
        end else if (wrap && !ctrl_reg[LIC_CTRL_FREEZE_BIT]) begin
            for (int m = 0; m < LIC_NUM_MOD; m++) begin
                levels.module_level[m] <= module_reg[m];
            end
            for (int c = 0; c < LIC_NUM_CH; c++) begin
                levels.channel_level[c] <= channel_reg[c];
            end
        end
    end

    // One duty generator per module
    for (genvar m = 0; m < LIC_NUM_MOD; m++) begin : g_module
        lic_scale u_scale (
            .hclk    (hclk),
            .hresetn (hresetn),
            .enable  (ctrl_reg[LIC_CTRL_EN_BIT]),
            .phase   (phase_reg),
            .code    (levels.module_level[m]),
            .drive   (module_drive[m])
        );
    end

    // One duty generator per channel
    for (genvar c = 0; c < LIC_NUM_CH; c++) begin : g_channel
        lic_scale u_scale (
            .hclk    (hclk),
            .hresetn (hresetn),
            .enable  (ctrl_reg[LIC_CTRL_EN_BIT]),
            .phase   (phase_reg),
            .code    (levels.channel_level[c]),
            .drive   (channel_drive[c])
        );
    end

endmodule
`default_nettype wire

// ===== dv/lic_regs_props.sv
// Concurrent checks on the register bank ports
`timescale 1ns/100ps
`default_nettype none
module lic_regs_props (
    // Clock and reset
    input wire logic                 hclk,
    input wire logic                 hresetn,
    // AHB-Lite slave
    input wire logic                 hsel,
    input wire logic [31:0]          haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic [2:0]           hsize,
    input wire logic [31:0]          hwdata,
    input wire logic                 hready,
    input wire logic [31:0]          hrdata,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    // Levels and drives
    input wire lic_pkg::lic_levels_t levels,
    input wire logic [4:0]           module_drive,
    input wire logic [3:0]           channel_drive
);
    import lic_pkg::*;
    logic req;
    assign req = hsel && hready && htrans[1];
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_ready_high: assert property (hreadyout) else $error("wait state inserted");
    a_resp_okay: assert property (!hresp) else $error("error response");
    a_idle_zero: assert property (!req |=> hrdata == 32'h0000_0000)
        else $error("read data outside data phase");
    a_unmapped_zero: assert property (
        req && !hwrite && haddr[11:2] < 10'h00a |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (
        req && !hwrite && haddr[11:2] < 10'h040 |=> hrdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_mod_zero: assert property (
        levels.module_level[1] == 8'h00 ##1 levels.module_level[1] == 8'h00
        |-> !module_drive[1]) else $error("module drive with code zero");
    a_chan_zero: assert property (
        levels.channel_level[2] == 8'h00 ##1 levels.channel_level[2] == 8'h00
        |-> !channel_drive[2]) else $error("channel drive with code zero");
    a_levels_hold: assert property (
        $changed(levels) |=> $stable(levels) [*8]) else $error("levels changed mid period");
endmodule

bind lic_regs lic_regs_props u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .levels(levels),
    .module_drive(module_drive), .channel_drive(channel_drive)
);
`default_nettype wire

// ===== dv/test_lic_regs.sv
// Self-checking bench for the intensity and colour-mix register bank
`timescale 1ns/100ps
`default_nettype none
module test_lic_regs;
    import lic_pkg::*;
    localparam logic [7:0] MCODE [5] = '{8'h80, 8'h00, 8'hff, 8'h40, 8'h01};
    localparam logic [7:0] CCODE [4] = '{8'hff, 8'h80, 8'h00, 8'hc3};
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    lic_levels_t levels;
    logic [4:0]  module_drive;
    logic [3:0]  channel_drive;
    int          n_errors = 0;
    int          checked = 0;
    int          cnt [9];
    logic [31:0] rd_word;

    always #25 hclk = ~hclk;

    lic_regs dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .levels(levels),
        .module_drive(module_drive), .channel_drive(channel_drive)
    );

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Address phase held until hready, then idle
    task automatic addr_phase(input logic [9:0] idx, input logic wr_en);
        hsel   <= 1'b1;
        haddr  <= {20'h0_0000, idx, 2'b00};
        htrans <= LIC_HTRANS_NONSEQ;
        hwrite <= wr_en;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        addr_phase(idx, 1'b1);
        hwdata <= {24'h00_0000, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask

    // Read data taken at the edge that ends the data phase
    task automatic rd(input logic [9:0] idx, output logic [31:0] d);
        addr_phase(idx, 1'b0);
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        d = hrdata;
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        rd(idx, d);
        chk(d, {24'h00_0000, exp});
    endtask

    // Count drive-high cycles over one whole period
    task automatic count_period();
        cnt = '{default: 0};
        repeat (1020) begin
            @(posedge hclk);
            for (int i = 0; i < 5; i++) cnt[i] += module_drive[i];
            for (int i = 0; i < 4; i++) cnt[5+i] += channel_drive[i];
        end
    endtask

    task automatic reset_vals();
        for (int i = 0; i < 5; i++) rd_chk(10'h00a + 10'(i), 8'hff);
        for (int i = 0; i < 4; i++) rd_chk(10'h00f + 10'(i), 8'h00);
        for (int i = 0; i < 5; i++) chk(32'(levels.module_level[i]), 32'(LIC_INT_RST));
        for (int i = 0; i < 4; i++) chk(32'(levels.channel_level[i]), 32'(LIC_MIX_RST));
        rd_chk(LIC_IDX_CTRL, 8'(LIC_CTRL_RST));
    endtask

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        reset_vals();
        $display("test reset values done");
        for (int i = 0; i < 9; i++) wr(10'h00a + 10'(i), 8'h5a ^ 8'(i));
        for (int i = 0; i < 9; i++) rd_chk(10'h00a + 10'(i), 8'h5a ^ 8'(i));
        // Neighbours outside the bank stay empty
        wr(10'h009, 8'h77);
        wr(10'h013, 8'h77);
        rd_chk(10'h009, 8'h00);
        rd_chk(10'h013, 8'h00);
        $display("test access done");
        for (int i = 0; i < 5; i++) wr(10'h00a + 10'(i), MCODE[i]);
        for (int i = 0; i < 4; i++) wr(10'h00f + 10'(i), CCODE[i]);
        // Last write landing means all landed at the same wrap
        for (int w = 0; w < 2100 && levels.channel_level[3] !== 8'hc3; w++) @(posedge hclk);
        for (int i = 0; i < 5; i++) chk(32'(levels.module_level[i]), 32'(MCODE[i]));
        for (int i = 0; i < 4; i++) chk(32'(levels.channel_level[i]), 32'(CCODE[i]));
        repeat (2) @(posedge hclk);
        // One full period of 255 steps of 4 clocks
        count_period();
        for (int i = 0; i < 5; i++) chk(32'(cnt[i]), 32'(MCODE[i]) * 4);
        for (int i = 0; i < 4; i++) chk(32'(cnt[5+i]), 32'(CCODE[i]) * 4);
        $display("test duty done");
        // Enable low holds every drive off
        wr(LIC_IDX_CTRL, 8'h00);
        rd_chk(LIC_IDX_CTRL, 8'h00);
        count_period();
        for (int i = 0; i < 9; i++) chk(32'(cnt[i]), 32'h0000_0000);
        // Freeze keeps live levels while programmed ones move
        wr(LIC_IDX_CTRL, 8'h03);
        wr(LIC_IDX_MODULE3, 8'h11);
        repeat (1100) @(posedge hclk);
        chk(32'(levels.module_level[0]), 32'(MCODE[0]));
        rd(LIC_IDX_STATUS, rd_word);
        chk(32'(rd_word[LIC_STAT_PEND_BIT]), 32'h0000_0001);
        wr(LIC_IDX_CTRL, 8'h01);
        repeat (1100) @(posedge hclk);
        chk(32'(levels.module_level[0]), 32'h0000_0011);
        rd(LIC_IDX_STATUS, rd_word);
        chk(32'(rd_word[LIC_STAT_PEND_BIT]), 32'h0000_0000);
        $display("test control done");
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        reset_vals();
        $display("test second reset done");
        summarize();
    end

    initial begin
        #1_000_000;
        n_errors++;
        $display("watchdog expired");
        summarize();
    end
endmodule
`default_nettype wire
